/* File: verilog/rx_pin_interface.sv */
/*
  Receive-side pin interface of a T1 framer: line/framer routing, frame and
  multiframe sync, receive data, signaling, alarms and an 8.192 MHz reference clock.
  Assumes all link clocks are slow against core_clk and are sampled by it;
  registers are reached over APB.
*/
// Overview of operation
// RULE_01: Frame sync pulses once per frame, one line clock wide.
// RULE_02: With elastic store on, multiframe pulse is one system clock wide.
// RULE_03: With elastic store off, multiframe pulse follows the line clock.
// RULE_04: Receive data updates on each line clock rising edge.
// RULE_05: System clock is supplied only with elastic store on, else held low.
// RULE_06: Signaling output updates on line or system clock rise per mode.
// RULE_07: Alarm select bit set one way shows sync search.
// RULE_08: Other way, alarm shows transmit clock idle for 5 us.
// RULE_09: Carrier loss output follows line interface carrier loss.
// RULE_10: Signaling freeze output high when frozen, automatic or manual.
// RULE_11: Reference clock output locked to the receive line clock.
// RULE_12: Line data outputs update on recovered clock rising edge.
// RULE_13: Recovered clock output is a buffered copy of the line clock.
// RULE_14: Framer samples its data inputs on framer clock falling edges.
// RULE_15: External logic may tie both framer data inputs for NRZ.
// RULE_16: Connect strap high routes line interface into the framer.
// RULE_17: Receive line clock is the 1.544 MHz framer clock.
// RULE_18: Elastic store enable bit selects line or system clock timing.
// RULE_19: With elastic store off, multiframe pulse is one line clock wide.
// RULE_20: Alarm and flag outputs are registered and follow their condition.
`timescale 1ns/100ps
module rx_pin_interface (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Line interface side
  input  wire logic        line_clock_in,
  input  wire logic        line_pos_in,
  input  wire logic        line_neg_in,
  input  wire logic        line_carrier_lost,
  output logic             line_pos_data_out,
  output logic             line_neg_data_out,
  output logic             recovered_clock_out,
  // Framer inputs and strap
  input  wire logic        framer_pos_data_in,
  input  wire logic        framer_neg_data_in,
  input  wire logic        framer_clock_in,
  input  wire logic        line_interface_connect_strap,
  // System side
  input  wire logic        rx_system_clock,
  input  wire logic        transmit_line_clock,
  input  wire logic        sig_bit_in,
  output logic             frame_sync_out,
  output logic             multiframe_sync_out,
  output logic             rx_data_out,
  output logic             rx_signaling_out,
  output logic             sync_or_tx_clock_loss_alarm,
  output logic             carrier_loss_out,
  output logic             signaling_freeze_out,
  output logic             eight_meg_ref_clock
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic lclk_lvl, lclk_rise, lclk_fall;
  logic fclk_lvl, fclk_rise, fclk_fall;
  logic sclk_rise, transmit_line_clock_rise, transmit_line_clock_fall;
  logic lpos_s, lneg_s, fpos_s, fneg_s, carr_s, strap_s, sig_s;
  logic [6:0] raw_in;
  logic [6:0] meta_ff;
  logic [6:0] sync_ff;

  edge_sync u_lclk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(line_clock_in), .level(lclk_lvl), .rise(lclk_rise), .fall(lclk_fall));
  edge_sync u_fclk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(framer_clock_in), .level(fclk_lvl), .rise(fclk_rise), .fall(fclk_fall));
  edge_sync u_sclk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(rx_system_clock), .level(), .rise(sclk_rise), .fall());
  edge_sync u_transmit_line_clock (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .async_in(transmit_line_clock), .level(), .rise(transmit_line_clock_rise), .fall(transmit_line_clock_fall));

  assign raw_in = {sig_bit_in, line_interface_connect_strap, line_carrier_lost,
                   framer_neg_data_in, framer_pos_data_in, line_neg_in, line_pos_in};

  // Non-clock pins share one two-stage bank
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 7'h00;
      sync_ff <= 7'h00;
    end else if (clk_en) begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  assign {sig_s, strap_s, carr_s, fneg_s, fpos_s, lneg_s, lpos_s} = sync_ff;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [3:0] ctrl_ff;
  logic       wr_en, rd_en, addr_ok;
  logic       elastic_en, alarm_sel;

  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & ~penable & ~pwrite;
  assign addr_ok    = (paddr == rx_pins_pkg::ctrl_off) | (paddr == rx_pins_pkg::status_off)
                    | (paddr == rx_pins_pkg::frame_off);
  assign elastic_en = ctrl_ff[rx_pins_pkg::elastic_en_bit];  // see RULE_18
  assign alarm_sel  = ctrl_ff[rx_pins_pkg::alarm_sel_bit];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= rx_pins_pkg::ctrl_rst;
    end else if (clk_en && wr_en && paddr == rx_pins_pkg::ctrl_off) begin
      ctrl_ff <= pwdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Line interface outputs and framer routing
  // ---------------------------------------------------------------
  logic fr_clk_rise, fr_clk_fall, fr_pos, fr_neg;

  // Strap high bypasses the framer pins entirely
  assign fr_clk_rise = strap_s ? lclk_rise : fclk_rise;  // see RULE_16
  assign fr_clk_fall = strap_s ? lclk_fall : fclk_fall;
  assign fr_pos      = strap_s ? line_pos_data_out : fpos_s;
  assign fr_neg      = strap_s ? line_neg_data_out : fneg_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_pos_data_out   <= 1'b0;
      line_neg_data_out   <= 1'b0;
      recovered_clock_out <= 1'b0;
    end else if (clk_en) begin
      recovered_clock_out <= lclk_lvl;  // see RULE_13
      if (lclk_rise) begin
        line_pos_data_out <= lpos_s;  // see RULE_12
        line_neg_data_out <= lneg_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // Framer: bit and frame counting
  // ---------------------------------------------------------------
  logic [7:0] bit_cnt_ff;
  logic [3:0] frm_cnt_ff;
  logic       smp_bit_ff;
  logic       frame_end, mframe_end;
  logic [1:0] search_ff;
  logic       in_search;

  assign frame_end  = fr_clk_rise && bit_cnt_ff == 8'(rx_pins_pkg::bits_per_frame - 1);
  assign mframe_end = frame_end && frm_cnt_ff == 4'(rx_pins_pkg::frames_per_mframe - 1);
  assign in_search  = search_ff != 2'h0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 8'h00;
      frm_cnt_ff <= 4'h0;
      smp_bit_ff <= 1'b0;
    end else if (clk_en) begin
      if (fr_clk_fall) begin
        smp_bit_ff <= fr_pos | fr_neg;  // see RULE_14, RULE_15
      end
      if (fr_clk_rise) begin  // see RULE_17
        bit_cnt_ff <= frame_end ? 8'h00 : bit_cnt_ff + 8'h01;
        if (frame_end) begin
          frm_cnt_ff <= mframe_end ? 4'h0 : frm_cnt_ff + 4'h1;
        end
      end
    end
  end

  // Search clears after a few full frames from reset or carrier loss
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      search_ff <= 2'h3;
    end else if (clk_en) begin
      if (carr_s) begin
        search_ff <= 2'h3;
      end else if (frame_end && in_search) begin
        search_ff <= search_ff - 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sync pulses, data and signaling
  // ---------------------------------------------------------------
  logic mf_pend_ff;
  logic out_rise;

  // Elastic store picks the output timing clock
  assign out_rise = elastic_en ? sclk_rise : fr_clk_rise;  // see RULE_06, RULE_18

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_sync_out      <= 1'b0;
      multiframe_sync_out <= 1'b0;
      mf_pend_ff          <= 1'b0;
      rx_data_out         <= 1'b0;
      rx_signaling_out    <= 1'b0;
    end else if (clk_en) begin
      if (fr_clk_rise) begin
        frame_sync_out <= frame_end;  // see RULE_01
        rx_data_out    <= smp_bit_ff;  // see RULE_04
      end
      // A boundary that meets a timing edge goes straight out; holding it
      // pending as well would stretch the pulse to two periods
      if (out_rise) begin
        mf_pend_ff <= 1'b0;
      end else if (mframe_end) begin
        mf_pend_ff <= 1'b1;
      end
      if (out_rise) begin
        multiframe_sync_out <= mf_pend_ff | mframe_end;  // see RULE_02, RULE_03, RULE_19
        rx_signaling_out    <= sig_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // Alarms and flags
  // ---------------------------------------------------------------
  logic [7:0] transmit_line_clock_idle_ff;
  logic       transmit_line_clock_lost;

  assign transmit_line_clock_lost = transmit_line_clock_idle_ff >= 8'(rx_pins_pkg::transmit_line_clock_loss_cyc);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_line_clock_idle_ff <= 8'h00;
    end else if (clk_en) begin
      if (transmit_line_clock_rise || transmit_line_clock_fall) begin
        transmit_line_clock_idle_ff <= 8'h00;
      end else if (!transmit_line_clock_lost) begin
        transmit_line_clock_idle_ff <= transmit_line_clock_idle_ff + 8'h01;  // see RULE_08
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_or_tx_clock_loss_alarm <= 1'b0;
      carrier_loss_out            <= 1'b0;
      signaling_freeze_out        <= 1'b0;
    end else if (clk_en) begin
      sync_or_tx_clock_loss_alarm <= alarm_sel ? transmit_line_clock_lost : in_search;  // see RULE_07, RULE_20
      carrier_loss_out            <= carr_s;  // see RULE_09
      signaling_freeze_out        <= ctrl_ff[rx_pins_pkg::manual_frz_bit]
                                   | (ctrl_ff[rx_pins_pkg::auto_frz_bit] & (carr_s | in_search));  // see RULE_10
    end
  end

  // ---------------------------------------------------------------
  // Reference clock
  // ---------------------------------------------------------------
  // Core clock cannot make a true 8.192 MHz; a phase accumulator re-zeroed
  // on each line clock rise keeps the average locked to that clock.
  logic [23:0] acc_ff;
  logic [24:0] acc_sum;

  assign acc_sum = {1'b0, acc_ff} + 25'(2 * rx_pins_pkg::ref_clk_hz / 1000 * 16);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff              <= 24'h000000;
      eight_meg_ref_clock <= 1'b0;
    end else if (clk_en) begin
      if (lclk_rise) begin
        acc_ff <= 24'h000000;  // see RULE_11
      end else if (acc_sum >= 25'(rx_pins_pkg::core_clk_hz / 1000 * 16)) begin
        acc_ff              <= 24'(acc_sum - 25'(rx_pins_pkg::core_clk_hz / 1000 * 16));
        eight_meg_ref_clock <= ~eight_meg_ref_clock;
      end else begin
        acc_ff <= acc_sum[23:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave: zero wait states
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  assign rd_mux = (paddr == rx_pins_pkg::ctrl_off)   ? {28'h0000000, ctrl_ff} :
                  (paddr == rx_pins_pkg::status_off) ? {26'h0000000, transmit_line_clock_lost, in_search,
                                                        carr_s, strap_s, elastic_en, alarm_sel} :
                  (paddr == rx_pins_pkg::frame_off)  ? {20'h00000, frm_cnt_ff, bit_cnt_ff} :
                  32'h00000000;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule

/* File: verilog/rx_pins_pkg.sv */
/*
  Package for the receive-side pin interface: register map, field positions,
  reset values and timing counts.
  Assumes a 25 MHz core clock and a 32-bit APB slave.
*/
package rx_pins_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] frame_off  = 8'h08;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int elastic_en_bit   = 0;
  localparam int alarm_sel_bit    = 1;
  localparam int manual_frz_bit   = 2;
  localparam int auto_frz_bit     = 3;
  localparam logic [3:0] ctrl_rst = 4'h0;

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam int bits_per_frame    = 193;
  localparam int frames_per_mframe = 12;
  localparam int ref_clk_hz        = 8192000;
  localparam int line_clk_hz       = 1544000;
  localparam int ref_div           = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int core_clk_hz     = 25000000;
  localparam int transmit_line_clock_loss_ns    = 5000;
  localparam int transmit_line_clock_loss_cyc   = (transmit_line_clock_loss_ns * (core_clk_hz / 1000000)) / 1000;
  localparam int sync_search_lim = 4;

endpackage

/* File: verilog/edge_sync.sv */
/*
  Two-stage synchroniser with rise and fall strobes taken from the second stage.
  Assumes the input is asynchronous to core_clk.
*/
`timescale 1ns/100ps
module edge_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = clk_en & sync_ff & ~prev_ff;
  assign fall  = clk_en & ~sync_ff & prev_ff;

endmodule

/* File: tb/rx_pin_checker.sv */
/*
  Port-level checker for rx_pin_interface, bound into it.
  Assumes a 40 ns core clock and a line clock near 320 ns.
*/
`timescale 1ns/100ps
module rx_pin_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       line_clock_in,
  input wire logic       line_pos_in,
  input wire logic       line_carrier_lost,
  input wire logic       line_pos_data_out,
  input wire logic       recovered_clock_out,
  input wire logic       frame_sync_out,
  input wire logic       multiframe_sync_out,
  input wire logic       carrier_loss_out
);
  // ---------------------------------------------------------------
  // Frame spacing counter, saturates so a stall cannot wrap
  // ---------------------------------------------------------------
  logic [11:0] fcnt_ff;
  logic        fseen_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_ff  <= 12'h000;
      fseen_ff <= 1'b0;
    end else begin
      fcnt_ff  <= $rose(frame_sync_out) ? 12'h001 : fcnt_ff + {11'h000, fcnt_ff != 12'hfff};
      fseen_ff <= fseen_ff | $rose(frame_sync_out);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_apb_answer: assert property (psel && !penable |=> pready && penable)
    else $error("no answer one cycle after setup");
  a_unmapped_err: assert property (psel && !penable && !(paddr inside {8'h00, 8'h04, 8'h08})
    |=> pslverr) else $error("unmapped access not refused");
  a_fsync_width: assert property ($rose(frame_sync_out) |-> frame_sync_out[*6] ##[1:4] !frame_sync_out)
    else $error("frame sync width wrong");
  a_fsync_period: assert property ($rose(frame_sync_out) && fseen_ff |-> fcnt_ff inside {[12'h604:12'h60c]})
    else $error("frame sync spacing wrong");
  a_mfsync_width: assert property ($rose(multiframe_sync_out) |-> ##[1:15] !multiframe_sync_out)
    else $error("multiframe sync too wide");
  a_carrier_set: assert property (line_carrier_lost[*6] |-> carrier_loss_out)
    else $error("carrier loss not flagged");
  a_carrier_clear: assert property (!line_carrier_lost[*6] |-> !carrier_loss_out)
    else $error("carrier loss flag stuck");
  a_recovered_clock: assert property ($rose(line_clock_in) |-> ##[1:5] recovered_clock_out)
    else $error("recovered clock not following");
  a_line_data: assert property ($changed(line_pos_data_out) |-> line_pos_data_out == $past(line_pos_in, 4))
    else $error("line data out not from line");
  c_frame: cover property ($rose(frame_sync_out));
  c_mframe: cover property ($rose(multiframe_sync_out));
  c_refused: cover property (pready && pslverr);
  c_carrier: cover property ($rose(carrier_loss_out));
endmodule

bind rx_pin_interface rx_pin_checker u_chk (.core_clk, .rst_n, .psel, .penable, .paddr,
  .pready, .pslverr, .line_clock_in, .line_pos_in, .line_carrier_lost, .line_pos_data_out,
  .recovered_clock_out, .frame_sync_out, .multiframe_sync_out, .carrier_loss_out);

/* File: tb/rx_far_side.sv */
/*
  Far side model: line interface clock and data, system and transmit clocks.
  Assumes the bench sets sys_en with the elastic store bit and tx_stop to idle the transmit clock.
*/
`timescale 1ns/100ps
module rx_far_side (
  input  wire logic sys_en,
  input  wire logic tx_stop,
  output logic      line_clock_in,
  output logic      line_pos_in,
  output logic      line_neg_in,
  output logic      framer_pos_data_in,
  output logic      framer_neg_data_in,
  output logic      framer_clock_in,
  output logic      rx_system_clock,
  output logic      transmit_line_clock,
  output logic      sig_bit_in
);
  logic [7:0] pat_ff = 8'ha5;
  initial begin
    line_clock_in = 1'b0;
    forever #160 line_clock_in = ~line_clock_in;
  end
  // Data moves on the fall so it is steady around the sampling rise
  always @(negedge line_clock_in) pat_ff <= {pat_ff[6:0], pat_ff[7] ^ pat_ff[5]};
  assign line_pos_in = pat_ff[0];
  assign line_neg_in = pat_ff[1] & ~pat_ff[0];
  assign sig_bit_in = pat_ff[2];
  assign framer_clock_in = line_clock_in;
  assign framer_pos_data_in = line_pos_in;
  assign framer_neg_data_in = line_pos_in;
  initial begin
    rx_system_clock = 1'b0;
    forever #244 rx_system_clock = sys_en ? ~rx_system_clock : 1'b0;
  end
  initial begin
    transmit_line_clock = 1'b0;
    forever #324 transmit_line_clock = tx_stop ? transmit_line_clock : ~transmit_line_clock;
  end
endmodule

/* File: tb/rx_pin_interface_tb.sv */
/*
  Self-checking bench for rx_pin_interface with the far side model.
  Assumes APB answers in the cycle after setup and a 25 MHz core clock.
*/
`timescale 1ns/100ps
module rx_pin_interface_tb;
  logic core_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sys_en, tx_stop, line_carrier_lost, line_interface_connect_strap;
  logic line_clock_in, line_pos_in, line_neg_in, framer_pos_data_in, framer_neg_data_in;
  logic framer_clock_in, rx_system_clock, transmit_line_clock, sig_bit_in;
  logic line_pos_data_out, line_neg_data_out, recovered_clock_out, frame_sync_out;
  logic multiframe_sync_out, rx_data_out, rx_signaling_out, sync_or_tx_clock_loss_alarm;
  logic carrier_loss_out, signaling_freeze_out, eight_meg_ref_clock;
  int n_errors = 0;
  int tests_run = 0;
  rx_far_side u_far (.sys_en, .tx_stop, .line_clock_in, .line_pos_in, .line_neg_in,
    .framer_pos_data_in, .framer_neg_data_in, .framer_clock_in, .rx_system_clock,
    .transmit_line_clock, .sig_bit_in);
  rx_pin_interface u_dut (.core_clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .line_clock_in, .line_pos_in, .line_neg_in,
    .line_carrier_lost, .line_pos_data_out, .line_neg_data_out, .recovered_clock_out,
    .framer_pos_data_in, .framer_neg_data_in, .framer_clock_in, .line_interface_connect_strap,
    .rx_system_clock, .transmit_line_clock, .sig_bit_in, .frame_sync_out, .multiframe_sync_out,
    .rx_data_out, .rx_signaling_out, .sync_or_tx_clock_loss_alarm, .carrier_loss_out,
    .signaling_freeze_out, .eight_meg_ref_clock);
  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("unexpected at %0t: got %h range %h to %h", $time, v, lo, hi);
    end
  endtask
  // One idle cycle follows each transfer so no strobe is assigned twice at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    chk_rng(n, 1, 1);
  endtask
  // Waits for a rise, measures its width and the span to the next rise
  task automatic pulse(input bit mf, input int lim, output int w, output int p);
    int n;
    n = 0;
    while ((mf ? multiframe_sync_out : frame_sync_out) !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    while ((mf ? multiframe_sync_out : frame_sync_out) !== 1'b1 && n < 25000) begin
      @(posedge core_clk);
      n++;
    end
    w = 0;
    while ((mf ? multiframe_sync_out : frame_sync_out) === 1'b1 && w < 50) begin
      @(posedge core_clk);
      w++;
    end
    p = w;
    while ((mf ? multiframe_sync_out : frame_sync_out) !== 1'b1 && p < lim) begin
      @(posedge core_clk);
      p++;
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    apb(1'b0, rx_pins_pkg::ctrl_off, 32'h0, q);
    chk(q, 32'h0);
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'hffffffff, q);
    apb(1'b0, rx_pins_pkg::ctrl_off, 32'h0, q);
    chk(q, 32'h0000000f);
    apb(1'b0, rx_pins_pkg::status_off, 32'h0, q);
    chk(q[2:0], 3'h7);
    apb(1'b1, 8'h10, 32'h5, q);
    chk(last_err, 1'b1);
    apb(1'b0, 8'h10, 32'h0, q);
    chk(last_err, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'h0, q);
    $display("test regs done");
  endtask
  task automatic t_frame;
    int w, p, t, lo, hi;
    logic b0, r;
    pulse(1'b0, 3000, w, p);
    chk_rng(w, 7, 9);
    chk_rng(p, 1540, 1548);
    pulse(1'b1, 25000, w, p);
    chk_rng(w, 7, 9);
    chk_rng(p, 18520, 18536);
    // Looked at one core cycle before the line clock falls, while the bit stands
    while (recovered_clock_out !== 1'b0) @(posedge core_clk);
    while (recovered_clock_out !== 1'b1) @(posedge core_clk);
    chk(line_neg_data_out, line_neg_in);
    b0 = line_pos_in | line_neg_in;
    while (recovered_clock_out !== 1'b0) @(posedge core_clk);
    while (recovered_clock_out !== 1'b1) @(posedge core_clk);
    chk(rx_data_out, b0);
    chk(rx_signaling_out, sig_bit_in);
    // Phase restart at each line clock rise drops toggles, so half rate is the floor
    lo = rx_pins_pkg::ref_clk_hz / (rx_pins_pkg::core_clk_hz / 1000);
    hi = 2 * lo + 1;
    t = 0;
    r = eight_meg_ref_clock;
    repeat (1000) begin
      @(posedge core_clk);
      t += (eight_meg_ref_clock !== r);
      r = eight_meg_ref_clock;
    end
    chk_rng(t, lo, hi);
    $display("test frame done");
  endtask
  task automatic t_alarm;
    logic [31:0] q;
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'h2, q);
    repeat (20) @(posedge core_clk);
    chk(sync_or_tx_clock_loss_alarm, 1'b0);
    tx_stop <= 1'b1;
    repeat (100) @(posedge core_clk);
    chk(sync_or_tx_clock_loss_alarm, 1'b0);
    repeat (40) @(posedge core_clk);
    chk(sync_or_tx_clock_loss_alarm, 1'b1);
    tx_stop <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk(sync_or_tx_clock_loss_alarm, 1'b0);
    $display("test alarm done");
  endtask
  task automatic t_carrier;
    logic [31:0] q;
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'h8, q);
    line_carrier_lost <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(carrier_loss_out, 1'b1);
    chk(sync_or_tx_clock_loss_alarm, 1'b1);
    chk(signaling_freeze_out, 1'b1);
    line_carrier_lost <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(carrier_loss_out, 1'b0);
    repeat (5000) @(posedge core_clk);
    chk(sync_or_tx_clock_loss_alarm, 1'b0);
    chk(signaling_freeze_out, 1'b0);
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'h4, q);
    repeat (5) @(posedge core_clk);
    chk(signaling_freeze_out, 1'b1);
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'h0, q);
    repeat (5) @(posedge core_clk);
    chk(signaling_freeze_out, 1'b0);
    $display("test carrier done");
  endtask
  task automatic t_elastic;
    logic [31:0] q;
    int w, p;
    sys_en <= 1'b1;
    apb(1'b1, rx_pins_pkg::ctrl_off, 32'h1, q);
    apb(1'b0, rx_pins_pkg::status_off, 32'h0, q);
    chk(q[1], 1'b1);
    pulse(1'b1, 100, w, p);
    chk_rng(w, 11, 14);
    $display("test elastic done");
  endtask
  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #4000000;
    n_errors++;
    finish_test;
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sys_en, tx_stop, line_carrier_lost} = 3'h0;
    line_interface_connect_strap = 1'b1;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_frame;
    t_alarm;
    t_carrier;
    t_elastic;
    finish_test;
  end
endmodule
